/* design/vicinity_tag_air_codec.sv */
/*
  Air-interface symbol codec of a vicinity tag: pulse-position request decoder,
  Manchester subcarrier response encoder, AHB-Lite register slave.
  Assumes carrier_i and pause_i are asynchronous levels from the analog front
  end, pause_i high during a reader pause, and a single zero-wait AHB master.
*/
// What this block does
// - Quarter mode: pause among four 256-cycle slots
// - Byte is four pairs, lowest pair first
// - Receiver ready 311.5 us after response
// - Receiver blocked for 0.1 ms power-on
// - Request delimiter selects 1-of-256 or 1-of-4
// - Delimiters are code violations, never data
// - Header bit selects one or two subcarriers
// - Subcarrier switching keeps phase continuous
// - Header bit selects low or high rate
// - Double speed only with one subcarrier
// - Bit periods give the listed carrier ratios
// - Manchester; low x4, fast halved
// - High one-sub: 8 pulses, 18.88 us mirrored
// - Fast high: 4 pulses, 9.44 us mirrored
// - Low one-sub: 32 pulses, 75.52 us mirrored
// - Fast low: 16 pulses, 37.76 us mirrored
// - High two-sub: 8 at fc/32, 9 at fc/28
// - Low two-sub: 32 at fc/32, 36 at fc/28
// - High one-sub SOF: 56.64 us off, 24 pulses, one
// - Fast high SOF: 28.32 us, 12 pulses, one
// - Low one-sub SOF: 226.56 us, 96 pulses, one
// - Fast low SOF: 113.28 us, 48 pulses, one
// - 256 mode: pause slot index is byte value
module vicinity_tag_air_codec
  import tag_codec_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int PWRON_CYCLES = PWRON_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Air interface
  input wire logic carrier_i,
  input wire logic pause_i,
  output logic load_o
);

  state_s st; // Registered state
  state_s next_st; // Next state
  logic fct; // Carrier rising edge
  logic prs; // Pause start
  logic ready; // Receiver accepts a request
  logic fast_eff; // Double speed in force
  logic bit_v; // Bit being sent
  logic mod; // Segment is modulated
  logic s28; // Segment uses fc/28
  logic [11:0] u1; // One-subcarrier half bit
  logic [11:0] u32; // fc/32 half bit
  logic [11:0] u28; // fc/28 half bit
  logic [11:0] len; // Current segment length
  logic seg_end; // Last carrier cycle of segment
  logic sc_end; // Last cycle of subcarrier half period
  logic under_ev; // Transmit ran dry this cycle

  // Pause offset close to a delimiter spacing
  function automatic logic near(input logic [16:0] t, input logic [16:0] ref_t);
    near = (t + SOF_TOL_FC >= ref_t) && (t <= ref_t + SOF_TOL_FC);
  endfunction

  // Next-state logic: transmit, then bus, then receive, so sets win over clears
  always_comb begin
    next_st = st;
    under_ev = 1'b0;
    // Two-stage synchronisers plus an edge history stage
    next_st.car = {st.car[1:0], carrier_i};
    next_st.pau = {st.pau[1:0], pause_i};
    fct = st.car[1] & ~st.car[2];
    prs = st.pau[1] & ~st.pau[2];
    ready = (st.pwr == 17'h00000) && (st.gap == 17'h00000) && (st.tx == TX_IDLE);
    // Blocking timers run down on the system clock
    if (st.pwr != 17'h00000) begin
      next_st.pwr = st.pwr - 17'h00001;
    end
    if (st.gap != 17'h00000) begin
      next_st.gap = st.gap - 17'h00001;
    end
    // Double speed is ignored with two subcarriers
    fast_eff = st.fast & ~st.two;
    // Half-bit lengths from rate and speed
    u32 = st.high ? U32_HI : U32_LO;
    u28 = st.high ? U28_HI : U28_LO;
    u1 = fast_eff ? {1'b0, u32[11:1]} : u32;
    bit_v = st.sof_one | st.tx_sh[0];
    // Segment shape of the current phase
    case (st.tx)
      TX_SOF_OFF: begin
        // Unmodulated lead-in, three half bits long
        mod = 1'b0;
        s28 = 1'b0;
        len = u1 + u1 + u1;
      end
      TX_SOF_ON: begin
        // Burst of fc/32 pulses, three half bits long
        mod = 1'b1;
        s28 = 1'b0;
        len = u1 + u1 + u1;
      end
      TX_BIT_A, TX_BIT_B: begin
        if (st.two) begin
          // Zero: fc/32 then fc/28; one: the reverse
          mod = 1'b1;
          s28 = (st.tx == TX_BIT_A) ? bit_v : ~bit_v;
          len = s28 ? u28 : u32;
        end else begin
          // Zero: pulses then quiet; one: the reverse
          mod = (st.tx == TX_BIT_A) ? ~bit_v : bit_v;
          s28 = 1'b0;
          len = u1;
        end
      end
      default: begin
        mod = 1'b0;
        s28 = 1'b0;
        len = u1;
      end
    endcase
    seg_end = fct && (st.seg == len - 12'h001);
    sc_end = st.sc_cnt == (s28 ? SC28_LAST : SC32_LAST);
    // Load switch follows subcarrier while modulating
    next_st.load = (st.tx != TX_IDLE) & mod & st.sc_lvl;
    // Transmit sequencer, stepped by carrier edges
    if (st.tx != TX_IDLE && fct) begin
      next_st.seg = st.seg + 12'h001;
      if (sc_end) begin
        next_st.sc_cnt = 4'h0;
        next_st.sc_lvl = ~st.sc_lvl;
      end else begin
        next_st.sc_cnt = st.sc_cnt + 4'h1;
      end
      if (seg_end) begin
        // Segments hold whole pulses, so restarting the period is phase-true
        next_st.seg = 12'h000;
        next_st.sc_cnt = 4'h0;
        next_st.sc_lvl = 1'b1;
        case (st.tx)
          TX_SOF_OFF: next_st.tx = TX_SOF_ON;
          TX_SOF_ON: begin
            // Delimiter closes with a logic one
            next_st.tx = TX_BIT_A;
            next_st.sof_one = 1'b1;
          end
          TX_BIT_A: next_st.tx = TX_BIT_B;
          TX_BIT_B: begin
            next_st.tx = TX_BIT_A;
            if (st.sof_one) begin
              next_st.sof_one = 1'b0;
            end else if (st.tx_bit != 3'h7) begin
              // Bytes leave least significant bit first
              next_st.tx_bit = st.tx_bit + 3'h1;
              next_st.tx_sh = {1'b0, st.tx_sh[7:1]};
            end else if (st.tx_last) begin
              next_st.tx = TX_IDLE;
              next_st.gap = 17'(GAP_CYCLES);
            end else if (st.hvld) begin
              next_st.tx_sh = st.hold;
              next_st.tx_last = st.hlast;
              next_st.hvld = 1'b0;
              next_st.tx_bit = 3'h0;
            end else begin
              // No byte waiting: the frame is cut short
              next_st.tx = TX_IDLE;
              next_st.gap = 17'(GAP_CYCLES);
              under_ev = 1'b1;
            end
          end
          default: next_st.tx = TX_IDLE;
        endcase
      end
    end
    // Bus address phase; zero wait, always OKAY
    next_st.hready = 1'b1;
    next_st.hresp = 1'b0;
    next_st.a_vld = hsel_i & htrans_i[1] & hready_i;
    next_st.a_wr = hwrite_i;
    next_st.a_addr = haddr_i[7:0];
    next_st.hrdata = 32'h00000000;
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
      case (haddr_i[7:0])
        ADDR_CTRL: next_st.hrdata = {29'h00000000, st.fast, st.high, st.two};
        ADDR_STATUS: begin
          next_st.hrdata = {24'h000000, st.under, st.rx_err, st.m256, st.rx_done,
                            st.rx_vld, ready, ~st.hvld, st.tx != TX_IDLE};
        end
        ADDR_RXDATA: begin
          // Reading the byte frees the holding register
          next_st.hrdata = {24'h000000, st.rx_hold};
          next_st.rx_vld = 1'b0;
        end
        default: next_st.hrdata = 32'h00000000;
      endcase
    end
    // Bus data phase writes
    if (st.a_vld && st.a_wr) begin
      case (st.a_addr)
        ADDR_CTRL: begin
          // Header bits decoded upstream pick subcarriers, rate and speed
          next_st.two = hwdata_i[CTRL_TWO_SUB];
          next_st.high = hwdata_i[CTRL_HIGH_RATE];
          next_st.fast = hwdata_i[CTRL_DOUBLE_SPEED];
          if (hwdata_i[CTRL_START] && st.hvld && st.tx == TX_IDLE && st.rx == RX_IDLE) begin
            next_st.tx_sh = st.hold;
            next_st.tx_last = st.hlast;
            next_st.hvld = 1'b0;
            next_st.tx_bit = 3'h0;
            next_st.seg = 12'h000;
            next_st.sc_cnt = 4'h0;
            next_st.sc_lvl = 1'b1;
            next_st.sof_one = 1'b0;
            // Two subcarriers: no delimiter is sent, the first data bit starts at once
            next_st.tx = hwdata_i[CTRL_TWO_SUB] ? TX_BIT_A : TX_SOF_OFF;
          end
        end
        ADDR_TXDATA: begin
          next_st.hold = hwdata_i[7:0];
          next_st.hlast = hwdata_i[TXD_LAST];
          next_st.hvld = 1'b1;
        end
        ADDR_STATUS: begin
          // Write one to clear sticky flags
          if (hwdata_i[STAT_RX_DONE]) begin
            next_st.rx_done = 1'b0;
          end
          if (hwdata_i[STAT_RX_ERR]) begin
            next_st.rx_err = 1'b0;
          end
          if (hwdata_i[STAT_TX_UNDER]) begin
            next_st.under = 1'b0;
          end
        end
        default: begin end // Unmapped writes are dropped
      endcase
    end
    if (under_ev) begin
      next_st.under = 1'b1;
    end
    // Request decoder
    case (st.rx)
      RX_IDLE: begin
        // Requests before power-on or inside the gap are ignored
        if (prs && ready) begin
          next_st.rx = RX_SOF;
          next_st.sym = 17'h00000;
        end
      end
      RX_SOF: begin
        if (fct) begin
          next_st.sym = st.sym + 17'h00001;
        end
        if (prs) begin
          next_st.rx = RX_DATA;
          next_st.sym = SYM_PRE;
          next_st.got = 1'b0;
          next_st.pairs = 2'h0;
          if (near(st.sym, SOF256_FC)) begin
            next_st.m256 = 1'b1;
          end else if (near(st.sym, SOF4_FC)) begin
            next_st.m256 = 1'b0;
          end else begin
            next_st.rx = RX_IDLE;
            next_st.rx_err = 1'b1;
          end
        end else if (st.sym > SOF4_FC + SOF_TOL_FC) begin
          next_st.rx = RX_IDLE;
          next_st.rx_err = 1'b1;
        end
      end
      RX_DATA: begin
        // Symbol grid: 4 or 256 slots of 256 carrier cycles
        if (fct) begin
          if (st.sym == (st.m256 ? SYM256_LAST : SYM4_LAST)) begin
            next_st.sym = 17'h00000;
            next_st.got = 1'b0;
            if (!st.got) begin
              next_st.rx = RX_IDLE;
              next_st.rx_err = 1'b1;
            end
          end else begin
            next_st.sym = st.sym + 17'h00001;
          end
        end
        if (prs) begin
          if (st.sym[16] || st.got) begin
            next_st.rx = RX_IDLE;
            next_st.rx_err = 1'b1;
          end else if (!st.sym[7]) begin
            // Pause in a first half slot is the end violation
            next_st.rx = RX_IDLE;
            if (st.m256 || st.pairs == 2'h0) begin
              next_st.rx_done = 1'b1;
            end else begin
              next_st.rx_err = 1'b1;
            end
          end else begin
            // Second half pause: slot index is the value
            next_st.got = 1'b1;
            if (st.m256) begin
              next_st.rx_hold = st.sym[15:8];
              next_st.rx_vld = 1'b1;
            end else begin
              next_st.rx_sh = {st.sym[9:8], st.rx_sh[7:2]};
              next_st.pairs = st.pairs + 2'h1;
              if (st.pairs == 2'h3) begin
                next_st.rx_hold = {st.sym[9:8], st.rx_sh[7:2]};
                next_st.rx_vld = 1'b1;
              end
            end
          end
        end
      end
      default: next_st.rx = RX_IDLE;
    endcase
  end

  // State register; the power-on timer starts loaded
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.pwr <= 17'(PWRON_CYCLES);
      st.hready <= 1'b1;
      st.sc_lvl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign hrdata_o = st.hrdata;
  assign hreadyout_o = st.hready;
  assign hresp_o = st.hresp;
  assign load_o = st.load;

  a_gap_after_tx: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.tx != TX_IDLE ##1 st.tx == TX_IDLE) |-> (st.gap == 17'(GAP_CYCLES)) && !ready)
    else $error("gap not loaded after response");

  a_pwr_blocks_rx: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.pwr != 17'h00000) |-> (st.rx == RX_IDLE))
    else $error("request decoded during power-on");

  a_sof_mode_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.rx == RX_SOF && prs && near(st.sym, SOF256_FC)) |=> (st.m256 && st.rx == RX_DATA))
    else $error("1-of-256 delimiter not taken");

  a_eof_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.rx == RX_DATA && prs && !st.sym[16] && !st.got && !st.sym[7] && st.pairs == 2'h0)
    |=> (st.rx_done && st.rx == RX_IDLE))
    else $error("end violation did not complete frame");

  a_pair_order: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.rx == RX_DATA && !st.m256 && prs && st.sym[7] && !st.sym[16] && !st.got && st.pairs == 2'h3)
    |=> (st.rx_vld && st.rx_hold[7:6] == $past(st.sym[9:8]) && st.rx_hold[5:0] == $past(st.rx_sh[7:2])))
    else $error("quarter-mode byte assembled wrongly");

  a_two_sub_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.two && st.tx != TX_IDLE) |-> (len == U32_HI || len == U28_HI || len == U32_LO || len == U28_LO))
    else $error("double speed used with two subcarriers");

  a_phase_cont: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.tx != TX_IDLE && seg_end) |-> (sc_end && !st.sc_lvl))
    else $error("segment ended inside a subcarrier period");

  a_seg_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.tx != TX_IDLE) |-> (st.seg < len))
    else $error("segment counter overran");

  a_quiet_lead: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.tx == TX_SOF_OFF) |=> !load_o)
    else $error("load switched during unmodulated lead-in");

  a_zero_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st.tx == TX_BIT_A && !st.two && !bit_v && st.sc_lvl) |=> load_o)
    else $error("logic zero did not start with pulses");

endmodule // vicinity_tag_air_codec

/* design/tag_codec_pkg.sv */
/*
  Shared constants, types and the state record of the vicinity tag air codec.
  Assumes a 200 MHz system clock and a carrier clock well below half that rate.
*/
package tag_codec_pkg;

  // System clock rate, used to turn times into cycle counts
  localparam real CLK_MHZ = 200.0;
  // Gap from end of a response to a receiver ready for the next command
  localparam real RESP_TO_NEXT_COMMAND_GAP_US = 311.5;
  // Power-on delay after field activation
  localparam real PWRON_MS = 0.1;
  // Least times, so rounded up
  localparam int GAP_CYC = int'($ceil(RESP_TO_NEXT_COMMAND_GAP_US * CLK_MHZ));
  localparam int PWRON_CYC = int'($ceil(PWRON_MS * 1000.0 * CLK_MHZ));

  // Receive slot: 18.88 us, counted as carrier cycles
  localparam real SLOT_US = 18.88;
  localparam logic [16:0] SLOT_FC = 17'h00100;
  // Request delimiter spacings between the two pauses, in carrier cycles
  localparam logic [16:0] SOF256_FC = 17'h00300;
  localparam logic [16:0] SOF4_FC = 17'h00400;
  // Accepted spread of a delimiter pause, in carrier cycles
  localparam logic [16:0] SOF_TOL_FC = 17'h00020;
  // Last count of one symbol: 4 slots or 256 slots
  localparam logic [16:0] SYM4_LAST = 17'h003FF;
  localparam logic [16:0] SYM256_LAST = 17'h0FFFF;
  // Start value that lets the symbol grid begin half a slot after the delimiter
  localparam logic [16:0] SYM_PRE = 17'h1FF80;

  // Subcarriers: fc/32 and fc/28; last count of a half period
  localparam logic [3:0] SC32_LAST = 4'hF;
  localparam logic [3:0] SC28_LAST = 4'hD;
  // Manchester half bits in carrier cycles: 8 pulses fc/32, 9 pulses fc/28
  localparam logic [11:0] U32_HI = 12'h100;
  localparam logic [11:0] U28_HI = 12'h0FC;
  // Low rate is four times longer
  localparam logic [11:0] U32_LO = 12'h400;
  localparam logic [11:0] U28_LO = 12'h3F0;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  // Control fields
  localparam int CTRL_TWO_SUB = 0;
  localparam int CTRL_HIGH_RATE = 1;
  localparam int CTRL_DOUBLE_SPEED = 2;
  localparam int CTRL_START = 3;
  // Status fields
  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_TX_NEED = 1;
  localparam int STAT_RX_READY = 2;
  localparam int STAT_RX_VALID = 3;
  localparam int STAT_RX_DONE = 4;
  localparam int STAT_RX_MODE256 = 5;
  localparam int STAT_RX_ERR = 6;
  localparam int STAT_TX_UNDER = 7;
  // Transmit data: last-byte flag
  localparam int TXD_LAST = 8;

  // Transmit phases
  typedef enum logic [2:0] {TX_IDLE, TX_SOF_OFF, TX_SOF_ON, TX_BIT_A, TX_BIT_B} tx_e;
  // Receive phases
  typedef enum logic [1:0] {RX_IDLE, RX_SOF, RX_DATA} rx_e;

  // Whole state of the codec
  typedef struct packed {
    logic [2:0] car;
    logic [2:0] pau;
    logic a_vld;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic two;
    logic high;
    logic fast;
    tx_e tx;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic tx_last;
    logic [7:0] hold;
    logic hlast;
    logic hvld;
    logic sof_one;
    logic under;
    logic [11:0] seg;
    logic [3:0] sc_cnt;
    logic sc_lvl;
    logic load;
    logic [16:0] gap;
    logic [16:0] pwr;
    rx_e rx;
    logic [16:0] sym;
    logic got;
    logic m256;
    logic [1:0] pairs;
    logic [7:0] rx_sh;
    logic [7:0] rx_hold;
    logic rx_vld;
    logic rx_done;
    logic rx_err;
  } state_s;

endpackage

/* verification/reader_model.sv */
/*
  Behavioural reader at the far side of the air interface: a free-running carrier
  and a demodulated pause line that frames quarter-position requests.
  Assumes the tag samples both lines with its own clock; carrier period 125 ns.
*/
module reader_model (
  // Air side, as seen by the tag
  output logic carrier_o,
  output logic pause_o
);
  timeunit 1ns;
  timeprecision 100ps;

  int fc = 0; // Carrier rises seen so far

  // The field runs free, so the carrier never stops between frames
  // The 1 ns lead keeps every carrier edge clear of the tag's clock edges
  initial begin
    carrier_o = 1'b0;
    pause_o = 1'b0;
    #1;
    forever #62.5 carrier_o = ~carrier_o;
  end

  // Time base of every pause position, in carrier cycles
  always @(posedge carrier_o) begin
    fc <= fc + 1;
  end

  // One pause of 32 carrier cycles, short enough to stay inside half a slot
  task automatic pause_at(input int t);
    wait (fc >= t);
    pause_o = 1'b1;
    wait (fc >= t + 32);
    pause_o = 1'b0;
  endtask

  // A whole quarter-position request carrying one byte
  task automatic frame4(input logic [7:0] b);
    int s;
    int j;
    s = fc + 1; // First pause on a carrier edge, never on a bench clock edge
    pause_at(s); // Delimiter pair 1024 cycles apart picks quarter mode
    pause_at(s + 1024);
    for (j = 0; j < 4; j++) begin
      pause_at(s + 1152 + j * 1024 + int'(b[2 * j +: 2]) * 256 + 160);
    end
    pause_at(s + 1152 + 4096 + 32); // First-half pause is the closing violation
  endtask
endmodule // reader_model

/* verification/tb.sv */
/*
  Self-checking bench of the tag air codec: register access over AHB-Lite,
  reception of one quarter-position request, and the fast high-rate response start.
  Assumes the reader model drives the air inputs and the bench is the only master.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tag_codec_pkg::*;

  // Bus and clock
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  // Air side
  logic carrier;
  logic pause;
  logic load_o;
  // Score keeping
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] rd;

  // Short power-on and gap counts keep the run brief
  vicinity_tag_air_codec #(.GAP_CYCLES(20), .PWRON_CYCLES(50)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .carrier_i(carrier), .pause_i(pause), .load_o(load_o)
  );
  reader_model rdr (.carrier_o(carrier), .pause_o(pause));

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard: a full frame plus the response start stay well below this
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 200000) begin
      n_fail++;
      test_done();
    end
  end

  // Exact comparison on four-state values
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Range comparison for times that carry sampling jitter
  task automatic rng(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // Wait for hready at a rising edge; only the hang guard ends a stalled wait
  task automatic wait_rdy();
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) begin
      @(posedge sys_clk_i);
    end
  endtask

  // Single word write: address phase, then data phase
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= 1'b1;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
  endtask

  // Single word read; data taken at the edge that ends the data phase
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= 1'b0;
    wait_rdy();
    htrans_i <= 2'h0;
    wait_rdy();
    d = hrdata_o;
  endtask

  // Reset values and register access kinds
  task automatic t_regs();
    chk("hreadyout", 32'h1, {31'h0, hreadyout_o});
    chk("load_idle", 32'h0, {31'h0, load_o});
    ahb_rd(ADDR_STATUS, rd);
    chk("status_reset", 32'h6, rd);
    ahb_wr(ADDR_CTRL, 32'h7);
    ahb_rd(ADDR_CTRL, rd);
    chk("ctrl_rw", 32'h7, rd);
    ahb_wr(ADDR_CTRL, 32'h0);
    ahb_rd(ADDR_TXDATA, rd);
    chk("txdata_wo", 32'h0, rd);
    ahb_rd(8'h10, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp_o});
    $display("test regs done");
  endtask

  // One request byte in quarter mode, then flag handling
  task automatic t_rx();
    rdr.frame4(8'hE1);
    repeat (50) @(posedge sys_clk_i);
    ahb_rd(ADDR_STATUS, rd);
    chk("status_frame", 32'h1E, rd);
    ahb_rd(ADDR_RXDATA, rd);
    chk("rx_byte", 32'hE1, rd);
    ahb_rd(ADDR_STATUS, rd);
    chk("rx_valid_clr", 32'h16, rd);
    ahb_wr(ADDR_STATUS, 32'h10);
    ahb_rd(ADDR_STATUS, rd);
    chk("rx_done_w1c", 32'h6, rd);
    $display("test rx done");
  endtask

  // Fast high-rate start of response: 384 carrier quiet, 12 pulses, a closing one (128 quiet, 4 pulses), then a zero bit
  task automatic t_tx();
    int t;
    int n;
    logic prev;
    ahb_wr(ADDR_TXDATA, 32'h1A4); // Last byte; its lowest bit is a zero
    ahb_wr(ADDR_CTRL, 32'hE); // High rate with double speed, then start
    t = 0;
    while (load_o !== 1'b1 && t < 20000) begin
      @(posedge sys_clk_i);
      t++;
    end
    rng("sof_quiet", 9575, 9610, t);
    n = 1;
    prev = 1'b1;
    for (t = 0; t < 11000; t++) begin
      @(posedge sys_clk_i);
      if (load_o === 1'b1 && !prev) n++;
      prev = load_o;
    end
    chk("sof_pulses", 32'd12, n);
    while (!(load_o === 1'b1 && !prev) && t < 16000) begin
      prev = load_o;
      @(posedge sys_clk_i);
      t++;
    end
    rng("one_gap", 12770, 12830, t);
    // Pulses of the closing one run straight into those of a leading zero: 4 + 4
    n = 1;
    for (t = 0; t < 6300; t++) begin
      prev = load_o;
      @(posedge sys_clk_i);
      if (load_o === 1'b1 && !prev) n++;
    end
    chk("zero_pulses", 32'd8, n);
    $display("test tx done");
  endtask

  // Closing report and verdict
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (60) @(posedge sys_clk_i);
    t_regs();
    t_rx();
    t_tx();
    test_done();
  end
endmodule // tb
